//--- cio_pkg.sv
/*
  constants, layouts and carrier types of the configurable i/o port
  register block. assumes a host bus synchronous to the block clock.
*/
`default_nettype none
package cio_pkg;
  localparam int NPORT = 4;
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_D = 2'h3;
  // register kind sits in address bits 5:2, port in bits 1:0
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_DIR = 4'h1;
  localparam logic [3:0] OFS_DRIVE = 4'h2;
  localparam logic [3:0] OFS_DIN = 4'h3;
  localparam logic [3:0] OFS_DOUT = 4'h4;
  localparam logic [3:0] OFS_OCELL = 4'h5;
  localparam logic [3:0] OFS_MASK = 4'h6;
  localparam logic [3:0] OFS_ICELL = 4'h7;
  localparam logic [3:0] OFS_ENOUT = 4'h8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ALL_BITS = 8'hFF;
  localparam logic [7:0] PORT_D_BITS = 8'h07;
  localparam logic [7:0] SLEW_AB_BITS = 8'h0F;
  localparam logic [7:0] OD_AB_BITS = 8'hF0;
  localparam int DBE_BIT = 7;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cio_host_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] dir;
    logic [7:0] drive;
    logic [7:0] dout;
    logic [7:0] mask;
  } cio_cfg_t;
endpackage
`default_nettype wire

//--- cio_port_regs.sv
/*
  configuration and data registers of four general-purpose i/o ports,
  output and input cells, and pin driver control.
  assumes the host bus and the logic-array signals run on REF_CLK_IN;
  pin levels are asynchronous and are synchronised here.
*/
// Functional notes
// [RULE1] mode bit 0 gives host i/o, 1 gives latched address output
// [RULE2] mode register exists only for ports a and b
// [RULE3] direction bit 1 is output, 0 is input; reset to input
// [RULE4] pin drives when direction bit or logic-array enable term is set
// [RULE5] port d direction uses only its three lowest bits
// [RULE6] drive bit 1 on open-drain pin gives open drain, else push-pull
// [RULE7] drive bit 1 on slew pin gives fast slew, slow by default
// [RULE8] ports a and b: bits 3-0 slew, bits 7-4 open drain
// [RULE9] port c: all eight drive bits select open drain
// [RULE10] port d: three low drive bits select fast slew, rest unused
// [RULE11] input data read returns current pin levels on all ports
// [RULE12] output data register stores writes, drives enabled pins
// [RULE13] output cell read returns cells; write loads unmasked cells
// [RULE14] mask bit 1 blocks host load of its output cell; resets 0
// [RULE15] input cells store pin levels, feed logic array, host readable
// [RULE16] enable status reads 1 for driving, 0 for tri-stated pin
// [RULE17] first cell group routes to a or b, second to b or c
// [RULE18] in data port mode port a carries the host data byte
// [RULE19] port d feeds logic directly and may carry external selects
// [RULE20] port c bit 7 may serve as data byte enable input
// [RULE21] each register bit acts only on the pin of same position
// [RULE22] all configuration registers are zero after reset
// [RULE23] host reaches registers by plain reads and writes at offsets
// [RULE24] unused port d bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module cio_port_regs
  import cio_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // host register port
  input wire cio_host_t HOST_REQ_IN,
  output logic [7:0] HOST_RDATA_OUT,
  // port pins, index 0..3 is port a..d
  input wire logic [3:0][7:0] PIN_LVL_IN,
  output logic [3:0][7:0] PIN_DAT_OUT,
  output logic [3:0][7:0] PIN_OE_OUT,
  output logic [3:0][7:0] FAST_SLEW_OUT,
  output logic [3:0][7:0] OPEN_DRAIN_OUT,
  // logic array
  input wire logic [3:0][7:0] OE_TERM_IN,
  input wire logic [3:0][7:0] CELL_SEL_IN,
  input wire logic ROUTE_B_BC_IN,
  input wire logic [2:0] EXT_SELECT_IN,
  input wire logic [1:0][7:0] CELL_D_IN,
  input wire logic [1:0][7:0] CELL_LOAD_IN,
  output logic [1:0][7:0] OUTPUT_CELLS_OUT,
  input wire logic [2:0] ICELL_STORE_IN,
  output logic [2:0][7:0] INPUT_CELLS_OUT,
  output logic [2:0] PORT_D_LEVEL_OUT,
  // bus interface functions
  input wire logic [1:0][7:0] LATCH_ADDR_IN,
  input wire logic DATA_PORT_EN_IN,
  input wire logic [7:0] BUS_DATA_IN,
  input wire logic BUS_DATA_OE_IN,
  input wire logic DBE_EN_IN,
  output logic DATA_BYTE_ENABLE_OUT
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] width_mask(input logic [1:0] p);
    return (p == PORT_D) ? PORT_D_BITS : ALL_BITS;
  endfunction

  function automatic logic [7:0] od_mask(input logic [1:0] p);
    case (p)
      PORT_A, PORT_B: return OD_AB_BITS;
      PORT_C: return ALL_BITS;
      default: return REG_RESET;
    endcase
  endfunction

  function automatic logic [7:0] slew_mask(input logic [1:0] p);
    case (p)
      PORT_A, PORT_B: return SLEW_AB_BITS;
      PORT_D: return PORT_D_BITS;
      default: return REG_RESET;
    endcase
  endfunction

  // output cell group seen by a port's cell location
  function automatic logic cell_group(input logic [1:0] p,
                                      input logic rb);
    case (p)
      PORT_A: return 1'b0;
      PORT_B: return rb;
      default: return 1'b1;
    endcase
  endfunction

  // ****************************************************************
  // host decode
  // ****************************************************************
  logic wr_hit;
  logic rd_hit;
  logic [3:0] kind;
  logic [1:0] port;
  logic [7:0] wdat;

  assign wr_hit = HOST_REQ_IN.sel & HOST_REQ_IN.wr;
  assign rd_hit = HOST_REQ_IN.sel & HOST_REQ_IN.rd;
  assign kind = HOST_REQ_IN.addr[5:2];
  assign port = HOST_REQ_IN.addr[1:0];
  assign wdat = HOST_REQ_IN.wdata;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  cio_cfg_t cfg_q [NPORT];

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < NPORT; i++) begin
        cfg_q[i] <= '0; // RULE3 RULE22
      end
    end else if (wr_hit) begin // RULE23
      case (kind)
        OFS_MODE: begin
          if (port == PORT_A || port == PORT_B) begin // RULE2
            cfg_q[port].mode <= wdat; // RULE21
          end
        end
        OFS_DIR: cfg_q[port].dir <= wdat & width_mask(port); // RULE5 RULE24
        OFS_DRIVE: cfg_q[port].drive <= wdat & width_mask(port); // RULE24
        OFS_DOUT: cfg_q[port].dout <= wdat & width_mask(port); // RULE12
        OFS_MASK: begin
          if (port != PORT_D) begin
            cfg_q[port].mask <= wdat; // RULE14
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  logic [3:0][7:0] pin_s1_q;
  logic [3:0][7:0] pin_s2_q;

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= PIN_LVL_IN;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ****************************************************************
  // output cells
  // ****************************************************************
  logic [1:0][7:0] cell_q;
  logic cell_wr;
  logic cell_grp;

  assign cell_wr = wr_hit && kind == OFS_OCELL && port != PORT_D;
  assign cell_grp = cell_group(port, ROUTE_B_BC_IN); // RULE17

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cell_q <= '0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        for (int b = 0; b < 8; b++) begin
          if (cell_wr && cell_grp == g[0] && !cfg_q[port].mask[b]) begin
            cell_q[g][b] <= wdat[b]; // RULE13 RULE14
          end else if (CELL_LOAD_IN[g][b]) begin
            cell_q[g][b] <= CELL_D_IN[g][b];
          end
        end
      end
    end
  end

  assign OUTPUT_CELLS_OUT = cell_q;

  // ****************************************************************
  // input cells
  // ****************************************************************
  logic [2:0][7:0] icell_q;

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      icell_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ICELL_STORE_IN[i]) begin
          icell_q[i] <= pin_s2_q[i]; // RULE15
        end
      end
    end
  end

  assign INPUT_CELLS_OUT = icell_q; // RULE15
  assign PORT_D_LEVEL_OUT = pin_s2_q[PORT_D][2:0]; // RULE19

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  logic [3:0][7:0] dir_oe;
  logic [3:0][7:0] pin_dat;
  logic [3:0][7:0] logic_src;

  always_comb begin
    logic_src[PORT_A] = cell_q[0];
    logic_src[PORT_B] = cell_q[ROUTE_B_BC_IN]; // RULE17
    logic_src[PORT_C] = cell_q[1];
    logic_src[PORT_D] = {5'h00, EXT_SELECT_IN}; // RULE19
    for (int i = 0; i < NPORT; i++) begin
      dir_oe[i] = (cfg_q[i].dir | OE_TERM_IN[i]) & width_mask(i[1:0]); // RULE4
      for (int b = 0; b < 8; b++) begin
        if (cfg_q[i].mode[b]) begin
          pin_dat[i][b] = LATCH_ADDR_IN[i[0]][b]; // RULE1
        end else if (CELL_SEL_IN[i][b]) begin
          pin_dat[i][b] = logic_src[i][b];
        end else begin
          pin_dat[i][b] = cfg_q[i].dout[b]; // RULE12
        end
      end
    end
    if (DATA_PORT_EN_IN) begin
      dir_oe[PORT_A] = {8{BUS_DATA_OE_IN}}; // RULE18
      pin_dat[PORT_A] = BUS_DATA_IN; // RULE18
    end
    if (DBE_EN_IN) begin
      dir_oe[PORT_C][DBE_BIT] = 1'b0; // RULE20
    end
    for (int i = 0; i < NPORT; i++) begin
      OPEN_DRAIN_OUT[i] = cfg_q[i].drive & od_mask(i[1:0]); // RULE8 RULE9
      FAST_SLEW_OUT[i] = cfg_q[i].drive & slew_mask(i[1:0]); // RULE7 RULE10
      // open drain pins only pull low
      PIN_OE_OUT[i] = dir_oe[i] & ~(OPEN_DRAIN_OUT[i] & pin_dat[i]); // RULE6
    end
  end

  assign PIN_DAT_OUT = pin_dat;
  assign DATA_BYTE_ENABLE_OUT = DBE_EN_IN & pin_s2_q[PORT_C][DBE_BIT]; // RULE20

  // ****************************************************************
  // host read path
  // ****************************************************************
  logic [7:0] rd_val;
  logic [7:0] rdata_q;

  always_comb begin
    case (kind)
      OFS_MODE: rd_val = cfg_q[port].mode;
      OFS_DIR: rd_val = cfg_q[port].dir;
      OFS_DRIVE: rd_val = cfg_q[port].drive;
      OFS_DIN: rd_val = pin_s2_q[port] & width_mask(port); // RULE11
      OFS_DOUT: rd_val = cfg_q[port].dout; // RULE12
      OFS_OCELL:
        rd_val = (port == PORT_D) ? REG_RESET : cell_q[cell_grp]; // RULE13
      OFS_MASK: rd_val = cfg_q[port].mask;
      OFS_ICELL:
        rd_val = (port == PORT_D) ? REG_RESET : icell_q[port]; // RULE15
      OFS_ENOUT: rd_val = dir_oe[port]; // RULE16
      default: rd_val = REG_RESET;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_q <= REG_RESET;
    end else if (rd_hit) begin
      rdata_q <= rd_val; // RULE23
    end
  end

  assign HOST_RDATA_OUT = rdata_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_mode_only_ab: assert property (@(posedge REF_CLK_IN) // RULE2
    disable iff (RST_IN)
    cfg_q[PORT_C].mode == 8'h00 && cfg_q[PORT_D].mode == 8'h00)
    else $error("mode bits set on port without address output");

  a_oe_or_dir: assert property (@(posedge REF_CLK_IN) // RULE4
    disable iff (RST_IN)
    (!DATA_PORT_EN_IN && !DBE_EN_IN) |->
    dir_oe[PORT_C] == (cfg_q[PORT_C].dir | OE_TERM_IN[PORT_C]))
    else $error("driver enable is not direction or enable term");

  a_d_upper_zero: assert property (@(posedge REF_CLK_IN) // RULE24
    disable iff (RST_IN)
    cfg_q[PORT_D].dir[7:3] == 5'h00 && cfg_q[PORT_D].drive[7:3] == 5'h00
    && PIN_OE_OUT[PORT_D][7:3] == 5'h00)
    else $error("unused port d bits are active");

  a_din_read: assert property (@(posedge REF_CLK_IN) // RULE11
    disable iff (RST_IN)
    (rd_hit && kind == OFS_DIN && port == PORT_A) |=>
    HOST_RDATA_OUT == $past(pin_s2_q[PORT_A]))
    else $error("input data read differs from pin level");

  a_dout_back: assert property (@(posedge REF_CLK_IN) // RULE12
    disable iff (RST_IN)
    (wr_hit && kind == OFS_DOUT && port == PORT_B) ##1 !wr_hit ##1
    (rd_hit && kind == OFS_DOUT && port == PORT_B && !wr_hit) |=>
    HOST_RDATA_OUT == $past(wdat, 3))
    else $error("output data read back differs from write");

  a_mask_blocks: assert property (@(posedge REF_CLK_IN) // RULE14
    disable iff (RST_IN)
    (cell_wr && port == PORT_A && cfg_q[PORT_A].mask[0]
     && !CELL_LOAD_IN[0][0]) |=> $stable(cell_q[0][0]))
    else $error("masked output cell was loaded by host");

  a_cell_load: assert property (@(posedge REF_CLK_IN) // RULE13
    disable iff (RST_IN)
    (cell_wr && port == PORT_C && cfg_q[PORT_C].mask == 8'h00) |=>
    cell_q[1] == $past(wdat))
    else $error("unmasked output cell not loaded by host");

  a_od_pulls_low: assert property (@(posedge REF_CLK_IN) // RULE6
    disable iff (RST_IN)
    (OPEN_DRAIN_OUT[PORT_C][0] && pin_dat[PORT_C][0]) |->
    !PIN_OE_OUT[PORT_C][0])
    else $error("open drain pin drives high");

  a_slew_map: assert property (@(posedge REF_CLK_IN) // RULE8
    disable iff (RST_IN)
    FAST_SLEW_OUT[PORT_A][7:4] == 4'h0 && OPEN_DRAIN_OUT[PORT_A][3:0] == 4'h0
    && FAST_SLEW_OUT[PORT_C] == 8'h00)
    else $error("drive select bit acts on wrong function");

  a_mode_addr: assert property (@(posedge REF_CLK_IN) // RULE1
    disable iff (RST_IN)
    (cfg_q[PORT_B].mode[3] && !DATA_PORT_EN_IN) |->
    PIN_DAT_OUT[PORT_B][3] == LATCH_ADDR_IN[1][3])
    else $error("address output mode pin not carrying address");

  a_dir_drives: assert property (@(posedge REF_CLK_IN) // RULE3
    disable iff (RST_IN)
    cfg_q[PORT_B].dir[0] |-> dir_oe[PORT_B][0])
    else $error("direction bit set but driver not enabled");

  a_d_slew_only: assert property (@(posedge REF_CLK_IN) // RULE10
    disable iff (RST_IN)
    FAST_SLEW_OUT[PORT_D] == cfg_q[PORT_D].drive
    && OPEN_DRAIN_OUT[PORT_D] == 8'h00)
    else $error("port d drive bits not selecting slew only");

  a_c_open_drain: assert property (@(posedge REF_CLK_IN) // RULE9
    disable iff (RST_IN)
    OPEN_DRAIN_OUT[PORT_C] == cfg_q[PORT_C].drive)
    else $error("port c drive bit not selecting open drain");

  a_enout_read: assert property (@(posedge REF_CLK_IN) // RULE16
    disable iff (RST_IN)
    (rd_hit && kind == OFS_ENOUT && port == PORT_B) |=>
    HOST_RDATA_OUT == $past(dir_oe[PORT_B]))
    else $error("enable status read differs from driver enable");

  a_icell_store: assert property (@(posedge REF_CLK_IN) // RULE15
    disable iff (RST_IN)
    ICELL_STORE_IN[0] |=> INPUT_CELLS_OUT[0] == $past(pin_s2_q[PORT_A]))
    else $error("input cell did not store synchronised pin level");

  a_dbe_input: assert property (@(posedge REF_CLK_IN) // RULE20
    disable iff (RST_IN)
    DBE_EN_IN |-> !PIN_OE_OUT[PORT_C][DBE_BIT])
    else $error("byte enable pin is driven");

  a_route_b: assert property (@(posedge REF_CLK_IN) // RULE17
    disable iff (RST_IN)
    (!cfg_q[PORT_B].mode[0] && CELL_SEL_IN[PORT_B][0]) |->
    PIN_DAT_OUT[PORT_B][0] == (ROUTE_B_BC_IN ? cell_q[1][0] : cell_q[0][0]))
    else $error("port b cell source does not follow routing");

endmodule
`default_nettype wire

//--- cio_host_model.sv
/*
  host microcontroller model on the register bus of the i/o port block.
  assumes requests launch on the falling clock edge and that the block
  takes them on the next rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cio_host_model
  import cio_pkg::*;
(
  // clock
  input wire logic clk_in,
  // host bus
  output var cio_host_t req_out,
  input wire logic [7:0] rdata_in
);
  initial req_out = '0;

  // one access: request held over one rising edge, answer taken after it;
  // released address and data lines show inverted values so stale data is never reused
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_in);
    req_out = '{sel: 1'b1, rd: ~w, wr: w, addr: a, wdata: d};
    @(negedge clk_in);
    q = rdata_in;
    req_out = '{sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

//--- tb_configurable_io_port_registers.sv
/*
  self-checking bench of the i/o port register block against a model.
  assumes the host model and the block share REF_CLK_IN.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_configurable_io_port_registers;
  import cio_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cio_host_t req;
  logic [7:0] rdata, q, d, mk, bd = '0;
  logic [3:0][7:0] dat, oe, slew, od, lvl = '0, term = '0, csel = '0;
  logic [1:0][7:0] cells, cd = '0, cload = '0, lat = '0;
  logic [2:0][7:0] icells;
  logic [2:0] pdl, ext = '0, icst = '0;
  logic route = 1'b0, dpe = 1'b0, bdoe = 1'b0, dbe = 1'b0, dbeo;
  logic [7:0] m [9][4];
  logic [7:0] cl [2];
  int err_count = 0;
  int tests_run = 0;

  always #4 clk = ~clk;

  cio_host_model host_u (.clk_in(clk), .req_out(req), .rdata_in(rdata));

  cio_port_regs dut_u (
    .REF_CLK_IN(clk), .RST_IN(rst), .HOST_REQ_IN(req),
    .HOST_RDATA_OUT(rdata), .PIN_LVL_IN(lvl), .PIN_DAT_OUT(dat),
    .PIN_OE_OUT(oe), .FAST_SLEW_OUT(slew), .OPEN_DRAIN_OUT(od),
    .OE_TERM_IN(term), .CELL_SEL_IN(csel), .ROUTE_B_BC_IN(route),
    .EXT_SELECT_IN(ext), .CELL_D_IN(cd), .CELL_LOAD_IN(cload),
    .OUTPUT_CELLS_OUT(cells), .ICELL_STORE_IN(icst),
    .INPUT_CELLS_OUT(icells), .PORT_D_LEVEL_OUT(pdl),
    .LATCH_ADDR_IN(lat), .DATA_PORT_EN_IN(dpe), .BUS_DATA_IN(bd),
    .BUS_DATA_OE_IN(bdoe), .DBE_EN_IN(dbe), .DATA_BYTE_ENABLE_OUT(dbeo)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input int k, input int p, input logic [7:0] v);
    logic [7:0] x;
    host_u.xfer(1'b1, 6'(k * 4 + p), v, x);
  endtask

  task automatic rd(input int k, input int p, output logic [7:0] v);
    host_u.xfer(1'b0, 6'(k * 4 + p), 8'h00, v);
  endtask

  // bits of each configuration register kind that take a host write
  function automatic logic [7:0] wmask(input int k, input int p);
    case (k)
      0: return (p < 2) ? ALL_BITS : REG_RESET;
      1, 2, 4: return (p == 3) ? PORT_D_BITS : ALL_BITS;
      6: return (p < 3) ? ALL_BITS : REG_RESET;
      default: return REG_RESET;
    endcase
  endfunction

  task automatic pins();
    logic [7:0] pm, en, dt, o, s;
    for (int p = 0; p < 4; p++) begin
      pm = (p == 3) ? PORT_D_BITS : ALL_BITS;
      en = m[1][p] | term[p];
      dt = (m[0][p] & lat[p % 2]) | (~m[0][p] & m[4][p]);
      o = (p < 2) ? m[2][p] & OD_AB_BITS : (p == 2) ? m[2][p] : REG_RESET;
      s = (p < 2) ? m[2][p] & SLEW_AB_BITS : (p == 3) ? m[2][p] : REG_RESET;
      chk(dat[p] & pm, dt & pm);
      chk(oe[p] & pm, en & ~(o & dt) & pm);
      chk(od[p], o);
      chk(slew[p], s);
      if (p < 3) begin
        rd(8, p, q);
        chk(q, en);
      end
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  // ************************************
  // scenarios
  // ************************************
  initial begin
    void'($urandom(32'h4bcb7000));
    foreach (m[k, p]) m[k][p] = REG_RESET;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // every location, unmapped kinds included, reads zero after reset
    for (int a = 0; a < 64; a++) begin
      rd(a / 4, a % 4, q);
      chk(q, REG_RESET);
    end
    for (int r = 0; r < 3; r++) begin
      term = {8'h00, 24'($urandom)};
      lat = 16'($urandom);
      for (int k = 0; k < 7; k++) for (int p = 0; p < 4; p++)
        if (k != 3 && k != 5) begin
          d = 8'($urandom);
          wr(k, p, d);
          m[k][p] = d & wmask(k, p);
        end
      for (int k = 0; k < 7; k++) for (int p = 0; p < 4; p++)
        if (k != 3 && k != 5) begin
          rd(k, p, q);
          chk(q, m[k][p]);
        end
      // output data write followed closely by its read back
      d = 8'($urandom);
      wr(4, 1, d);
      m[4][1] = d;
      rd(4, 1, q);
      chk(q, m[4][1]);
      pins();
    end
    // pin levels, input cells, port d levels and byte enable
    dbe = 1'b1;
    lvl = 32'($urandom);
    repeat (3) @(negedge clk);
    icst = 3'h7;
    @(negedge clk);
    icst = 3'h0;
    for (int p = 0; p < 4; p++) begin
      rd(3, p, q);
      chk(q & wmask(1, p), lvl[p] & wmask(1, p));
      if (p < 3) begin
        rd(7, p, q);
        chk(q, lvl[p]);
        chk(icells[p], lvl[p]);
      end
    end
    chk({5'h0, pdl}, {5'h0, lvl[3][2:0]});
    chk({7'h0, dbeo}, {7'h0, lvl[2][7]});
    chk({7'h0, oe[2][7]}, 8'h00);
    dbe = 1'b0;
    // logic load, then masked host loads of both cell groups
    cd = 16'($urandom);
    cload = 16'hFFFF;
    @(negedge clk);
    cload = '0;
    cl[0] = cd[0];
    cl[1] = cd[1];
    // group 0 with bit 0 masked, group 1 unmasked and then masked
    for (int j = 0; j < 3; j++) begin
      int g;
      g = (j > 0);
      mk = (j == 1) ? 8'h00 : 8'($urandom) | {7'h00, j == 0};
      d = 8'($urandom);
      wr(6, 2 * g, mk);
      wr(5, 2 * g, d);
      cl[g] = (cl[g] & mk) | (d & ~mk);
      chk(cells[g], cl[g]);
      rd(5, 2 * g, q);
      chk(q, cl[g]);
    end
    // cell routing, external selects, then port a as host data bus
    wr(0, 0, REG_RESET);
    wr(0, 1, REG_RESET);
    wr(2, 0, REG_RESET);
    route = 1'b1;
    csel = {8'h07, 24'hFFFFFF};
    ext = 3'($urandom);
    #1;
    chk(dat[0], cl[0]);
    chk(dat[1], cl[1]);
    chk(dat[2], cl[1]);
    chk(dat[3] & PORT_D_BITS, {5'h0, ext});
    @(negedge clk);
    dpe = 1'b1;
    bdoe = 1'b1;
    bd = 8'($urandom);
    #1;
    chk(dat[0], bd);
    chk(oe[0], ALL_BITS);
    end_of_test();
  end
endmodule
`default_nettype wire
